/* npiu_map.svh */
// register offsets, field positions, reset values and vector constants of the interrupt unit
`ifndef NPIU_MAP_SVH
`define NPIU_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define NPIU_OFF_ENABLE   8'h00
`define NPIU_OFF_PRIO_LO  8'h04
`define NPIU_OFF_PRIO_HI  8'h08
`define NPIU_OFF_TRIGGER  8'h0C
`define NPIU_OFF_FLAGS    8'h10
`define NPIU_OFF_INSERV   8'h14
`define NPIU_OFF_EVT_STAT 8'h18
`define NPIU_OFF_EVT_MASK 8'h1C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define NPIU_EN_GLOBAL    7
`define NPIU_FLG_EXT0     0
`define NPIU_FLG_TMR0     1
`define NPIU_FLG_EXT1     2
`define NPIU_FLG_TMR1     3
`define NPIU_FLG_URX      4
`define NPIU_FLG_UTX      5
`define NPIU_FLG_TMR2     6
`define NPIU_FLG_T2EXT    7
`define NPIU_EVT_GRANT    0
`define NPIU_EVT_PREEMPT  1
`define NPIU_EVT_STRAY    2

// ----------------------------------------------------------------
// reset values and vectors
// ----------------------------------------------------------------
`define NPIU_RST_BYTE     8'h00
`define NPIU_RST_PRIO     6'h00
`define NPIU_RST_TRIG     2'h0
`define NPIU_RST_EVT      3'h0
`define NPIU_VEC_BASE     8'h03
`define NPIU_VEC_STRIDE   8'h08

`endif

/* npiu_pkg.sv */
// types shared by the nested priority interrupt unit
package npiu_pkg;

   // ----------------------------------------------------------------
   // call offer state machine, gray coded
   // ----------------------------------------------------------------
   typedef enum logic [0:0] {
      NPIU_IDLE  = 1'b0,
      NPIU_OFFER = 1'b1
   } npiu_fsm_t;

   // ----------------------------------------------------------------
   // whole state of the controller
   // ----------------------------------------------------------------
   typedef struct packed {
      npiu_fsm_t   fsm;
      logic [7:0]  en;
      logic [5:0]  plo;
      logic [5:0]  phi;
      logic [1:0]  trig;
      logic [7:0]  flags;
      logic [3:0]  isr;
      logic [2:0]  idx;
      logic [1:0]  lvl;
      logic [7:0]  vec;
      logic [2:0]  evt;
      logic [2:0]  mask;
      logic        rdy;
      logic        err;
      logic [31:0] rdata;
   } npiu_state_t;

   // ----------------------------------------------------------------
   // state of one external pin detector
   // ----------------------------------------------------------------
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic prev;
   } npiu_pin_t;

endpackage : npiu_pkg

/* npiu_arb_if.sv */
// request and winner signals between controller and arbiter
interface npiu_arb_if;
   logic [5:0]      req;
   logic [5:0][1:0] lvl;
   logic            win_valid;
   logic [2:0]      win_idx;
   logic [1:0]      win_lvl;

   modport arb (input req, input lvl, output win_valid, output win_idx, output win_lvl);
   modport ctl (output req, output lvl, input win_valid, input win_idx, input win_lvl);
endinterface : npiu_arb_if

/* npiu_pin_detect.sv */
// synchroniser and falling-edge detector for one active-low interrupt pin
module npiu_pin_detect
   import npiu_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic ce,
   input  wire logic pin_n,
   output logic      fall,
   output logic      low
);
   npiu_pin_t st_ff;
   npiu_pin_t nxt_st;

   // ----------------------------------------------------------------
   // next state: sync1 feeds only sync2
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st       = st_ff;
      nxt_st.sync1 = pin_n;
      nxt_st.sync2 = st_ff.sync1;
      nxt_st.prev  = st_ff.sync2;
   end

   // idle pin reads high, so no edge is seen out of reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '{sync1: 1'b1, sync2: 1'b1, prev: 1'b1};
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   // high in one sample, low in the next
   assign fall = st_ff.prev & ~st_ff.sync2;
   assign low  = ~st_ff.sync2;
endmodule : npiu_pin_detect

/* npiu_arbiter.sv */
// picks the highest-level enabled request, ties broken by fixed polling order
module npiu_arbiter
   import npiu_pkg::*;
(
   npiu_arb_if.arb a
);
   // ----------------------------------------------------------------
   // scan from last polled source down so the first polled wins ties
   // ----------------------------------------------------------------
   always_comb begin
      a.win_valid = 1'b0;
      a.win_idx   = 3'h0;
      a.win_lvl   = 2'h0;
      for (int i = 5; i >= 0; i--) begin
         if (a.req[i] && (!a.win_valid || a.lvl[i] >= a.win_lvl)) begin
            a.win_valid = 1'b1;
            a.win_idx   = 3'(i);
            a.win_lvl   = a.lvl[i];
         end
      end
   end
endmodule : npiu_arbiter

/* npiu_core.sv */
// nested priority interrupt controller with apb registers and core call handshake
// Notes on behaviour
// - grant enabled pending request when nothing of same or higher level is served
// - hold request pending while equal or higher level handler runs
// - higher level request pre-empts running handler at once
// - after pre-empting handler returns, interrupted lower handler stays in service
// - same-level ties: ext0, timer0, ext1, timer1, serial, timer2
// - vectors 03H, 0BH, 13H, 1BH, 23H, 2BH per source
// - acknowledge clears external flag only in transition mode
// - acknowledge clears timer0/timer1 flags, never serial or timer2 flags
// - level is high bit and low bit: 0 lowest to 3 highest
// - transition mode sets flag on high sample then low sample
// - return from handler ends current level's in-service state
// - hardware call pushes program counter only, no status word
//
// Design decisions made here: the placing of the registers and register access over APB.
`include "npiu_map.svh"
module npiu_core
   import npiu_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ext0_pin_n,
   input  wire logic        ext1_pin_n,
   input  wire logic        tmr0_ovf,
   input  wire logic        tmr1_ovf,
   input  wire logic        tmr2_ovf,
   input  wire logic        tmr2_ext,
   input  wire logic        uart_rx_done,
   input  wire logic        uart_tx_done,
   output logic             int_req,
   output logic [7:0]       int_vector,
   input  wire logic        call_ack,
   input  wire logic        return_from_handler,
   output logic [3:0]       in_service,
   output logic             irq
);
   npiu_state_t st_ff;
   npiu_state_t nxt_st;
   logic        ext0_fall;
   logic        ext0_low;
   logic        ext1_fall;
   logic        ext1_low;
   logic [5:0]  src;
   logic        grant_ok;
   logic        take;
   logic        wr;
   logic        rd_go;

   npiu_arb_if arb ();

   // ----------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------
   // highest level currently in service
   function automatic logic [1:0] top_level(input logic [3:0] isr);
      logic [1:0] t;
      t = 2'h0;
      for (int i = 0; i < 4; i++) begin
         if (isr[i]) begin
            t = 2'(i);
         end
      end
      return t;
   endfunction : top_level

   // one-hot of the highest in-service level
   function automatic logic [3:0] top_mask(input logic [3:0] isr);
      return 4'h1 << top_level(isr);
   endfunction : top_mask

   // fixed vector of a source
   function automatic logic [7:0] vector_of(input logic [2:0] idx);
      return 8'(`NPIU_VEC_BASE + 8'(idx) * `NPIU_VEC_STRIDE);
   endfunction : vector_of

   // ----------------------------------------------------------------
   // pin detectors and arbiter
   // ----------------------------------------------------------------
   npiu_pin_detect u_ext0 (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .pin_n   (ext0_pin_n),
      .fall    (ext0_fall),
      .low     (ext0_low)
   );

   npiu_pin_detect u_ext1 (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .pin_n   (ext1_pin_n),
      .fall    (ext1_fall),
      .low     (ext1_low)
   );

   npiu_arbiter u_arb (
      .a (arb.arb)
   );

   // ----------------------------------------------------------------
   // request sources and levels
   // ----------------------------------------------------------------
   // serial and timer 2 each share one vector between two flags
   assign src = {st_ff.flags[`NPIU_FLG_TMR2] | st_ff.flags[`NPIU_FLG_T2EXT],
                 st_ff.flags[`NPIU_FLG_URX] | st_ff.flags[`NPIU_FLG_UTX],
                 st_ff.flags[`NPIU_FLG_TMR1], st_ff.flags[`NPIU_FLG_EXT1],
                 st_ff.flags[`NPIU_FLG_TMR0], st_ff.flags[`NPIU_FLG_EXT0]};

   // masked sources never reach the arbiter, flags untouched
   assign arb.req = src & st_ff.en[5:0] & {6{st_ff.en[`NPIU_EN_GLOBAL]}};

   // level = {high bit, low bit}
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         arb.lvl[i] = {st_ff.phi[i], st_ff.plo[i]};
      end
   end

   // served only above the highest level in service
   assign grant_ok = arb.win_valid &&
                     (st_ff.isr == 4'h0 || arb.win_lvl > top_level(st_ff.isr));

   assign take  = call_ack && st_ff.fsm == NPIU_OFFER;
   assign wr    = psel && penable && pwrite && st_ff.rdy;
   assign rd_go = psel && penable && !st_ff.rdy;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st     = st_ff;
      nxt_st.rdy = 1'b0;
      nxt_st.err = 1'b0;

      // offer follows the arbiter; pause one cycle after a call
      unique case (st_ff.fsm)
         NPIU_IDLE: begin
            if (grant_ok) begin
               nxt_st.fsm = NPIU_OFFER;
            end
         end
         NPIU_OFFER: begin
            if (take || !grant_ok) begin
               nxt_st.fsm = NPIU_IDLE;
            end
         end
      endcase

      // any newer winner may replace the offered vector
      if (!take && grant_ok) begin
         nxt_st.idx = arb.win_idx;
         nxt_st.lvl = arb.win_lvl;
         nxt_st.vec = vector_of(arb.win_idx);
      end

      // software register writes, flag clears first so events win
      if (wr) begin
         unique case (paddr)
            `NPIU_OFF_ENABLE:   nxt_st.en    = pwdata[7:0];
            `NPIU_OFF_PRIO_LO:  nxt_st.plo   = pwdata[5:0];
            `NPIU_OFF_PRIO_HI:  nxt_st.phi   = pwdata[5:0];
            `NPIU_OFF_TRIGGER:  nxt_st.trig  = pwdata[1:0];
            `NPIU_OFF_FLAGS:    nxt_st.flags = st_ff.flags & ~pwdata[7:0];
            `NPIU_OFF_EVT_STAT: nxt_st.evt   = st_ff.evt & ~pwdata[2:0];
            `NPIU_OFF_EVT_MASK: nxt_st.mask  = pwdata[2:0];
            default: begin
            end
         endcase
      end

      // hardware flag clear on the call
      if (take) begin
         unique case (st_ff.idx)
            3'h0: if (st_ff.trig[0]) nxt_st.flags[`NPIU_FLG_EXT0] = 1'b0;
            3'h1: nxt_st.flags[`NPIU_FLG_TMR0] = 1'b0;
            3'h2: if (st_ff.trig[1]) nxt_st.flags[`NPIU_FLG_EXT1] = 1'b0;
            3'h3: nxt_st.flags[`NPIU_FLG_TMR1] = 1'b0;
            default: begin // serial and timer 2 stay for software
            end
         endcase
      end

      // hardware flag setting, wins over any clear in the same cycle
      if (st_ff.trig[0]) begin
         if (ext0_fall) nxt_st.flags[`NPIU_FLG_EXT0] = 1'b1;
      end else begin
         nxt_st.flags[`NPIU_FLG_EXT0] = ext0_low;
      end
      if (st_ff.trig[1]) begin
         if (ext1_fall) nxt_st.flags[`NPIU_FLG_EXT1] = 1'b1;
      end else begin
         nxt_st.flags[`NPIU_FLG_EXT1] = ext1_low;
      end
      if (tmr0_ovf)     nxt_st.flags[`NPIU_FLG_TMR0]  = 1'b1;
      if (tmr1_ovf)     nxt_st.flags[`NPIU_FLG_TMR1]  = 1'b1;
      if (uart_rx_done) nxt_st.flags[`NPIU_FLG_URX]   = 1'b1;
      if (uart_tx_done) nxt_st.flags[`NPIU_FLG_UTX]   = 1'b1;
      if (tmr2_ovf)     nxt_st.flags[`NPIU_FLG_TMR2]  = 1'b1;
      if (tmr2_ext)     nxt_st.flags[`NPIU_FLG_T2EXT] = 1'b1;

      // return ends only the top level; lower ones resume
      if (return_from_handler) begin
         if (st_ff.isr == 4'h0) begin
            nxt_st.evt[`NPIU_EVT_STRAY] = 1'b1;
         end
         nxt_st.isr = st_ff.isr & ~top_mask(st_ff.isr);
      end
      // call marks its level busy; core pushes only the pc
      if (take) begin
         nxt_st.isr[st_ff.lvl]           = 1'b1;
         nxt_st.evt[`NPIU_EVT_GRANT]     = 1'b1;
         if (st_ff.isr != 4'h0) begin
            nxt_st.evt[`NPIU_EVT_PREEMPT] = 1'b1;
         end
      end

      // apb read data and answer, one wait state
      if (rd_go) begin
         nxt_st.rdy   = 1'b1;
         nxt_st.rdata = 32'h0;
         unique case (paddr)
            `NPIU_OFF_ENABLE:   nxt_st.rdata[7:0] = st_ff.en;
            `NPIU_OFF_PRIO_LO:  nxt_st.rdata[5:0] = st_ff.plo;
            `NPIU_OFF_PRIO_HI:  nxt_st.rdata[5:0] = st_ff.phi;
            `NPIU_OFF_TRIGGER:  nxt_st.rdata[1:0] = st_ff.trig;
            `NPIU_OFF_FLAGS:    nxt_st.rdata[7:0] = st_ff.flags;
            `NPIU_OFF_INSERV:   nxt_st.rdata[3:0] = st_ff.isr;
            `NPIU_OFF_EVT_STAT: nxt_st.rdata[2:0] = st_ff.evt;
            `NPIU_OFF_EVT_MASK: nxt_st.rdata[2:0] = st_ff.mask;
            default:            nxt_st.err        = !pwrite;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // state register, frozen while ce is low
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '{fsm: NPIU_IDLE, en: `NPIU_RST_BYTE, plo: `NPIU_RST_PRIO,
                    phi: `NPIU_RST_PRIO, trig: `NPIU_RST_TRIG, flags: `NPIU_RST_BYTE,
                    isr: 4'h0, idx: 3'h0, lvl: 2'h0, vec: `NPIU_VEC_BASE,
                    evt: `NPIU_RST_EVT, mask: `NPIU_RST_EVT, rdy: 1'b0, err: 1'b0,
                    rdata: 32'h0};
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign prdata     = st_ff.rdata;
   assign pready     = st_ff.rdy;
   assign pslverr    = st_ff.rdy & st_ff.err;
   assign int_req    = st_ff.fsm == NPIU_OFFER;
   assign int_vector = st_ff.vec;
   assign in_service = st_ff.isr;
   assign irq        = |(st_ff.evt & st_ff.mask);

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   offer_level_ok_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      int_req && in_service != 4'h0 |-> st_ff.lvl > top_level(in_service))
      else $error("offered level not above level in service");

   equal_level_held_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && !int_req && arb.win_valid && in_service[3] && !return_from_handler |=> !int_req)
      else $error("request offered while top level busy");

   call_marks_level_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && take |=> in_service[$past(st_ff.lvl)] && !int_req)
      else $error("call did not mark its level in service");

   return_resumes_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && return_from_handler && !take && $countones(in_service) == 2
      |=> $countones(in_service) == 1)
      else $error("return did not leave interrupted level in service");

   vector_match_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      int_req |-> int_vector == 8'(8'h03 + {2'h0, st_ff.idx, 3'h0}))
      else $error("vector does not match offered source");

   edge_flag_clr_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && take && st_ff.idx == 3'h0 && st_ff.trig[0] && !ext0_fall |=> !st_ff.flags[0])
      else $error("transition flag not cleared on call");

   serial_flag_kept_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && take && st_ff.idx == 3'h4 && st_ff.flags[4] && !wr |=> st_ff.flags[4])
      else $error("serial flag cleared by hardware");

   timer_flag_clr_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && take && st_ff.idx == 3'h1 && !tmr0_ovf |=> !st_ff.flags[1])
      else $error("timer 0 flag not cleared on call");

   fall_sets_flag_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && st_ff.trig[0] && ext0_fall |=> st_ff.flags[0])
      else $error("falling edge did not set external 0 flag");

   global_off_quiet_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && !st_ff.en[7] |=> !int_req)
      else $error("request offered with global enable clear");

   tie_poll_order_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      arb.req[1] && !(arb.req[0] && arb.lvl[0] >= arb.lvl[1]) && arb.lvl[1] >= arb.win_lvl
      |-> arb.win_idx == 3'h1)
      else $error("timer 0 lost a tie it should win");

   higher_offered_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && !int_req && arb.win_valid && in_service != 4'h0 && arb.win_lvl > top_level(in_service) |=> int_req)
      else $error("higher level request not offered over running handler");

   stray_return_flag_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && return_from_handler && in_service == 4'h0 |=> st_ff.evt[`NPIU_EVT_STRAY])
      else $error("return with nothing in service not flagged");

   level_flag_follow_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && !st_ff.trig[0] |=> st_ff.flags[`NPIU_FLG_EXT0] == $past(ext0_low))
      else $error("level mode flag does not follow the pin");
endmodule : npiu_core

/* npiu_core_model.sv */
// processor core model that takes offered calls and returns from handlers
module npiu_core_model
   import npiu_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       int_req,
   input  wire logic [7:0] int_vector,
   input  wire logic       ret_cmd,
   output logic            call_ack,
   output logic            return_from_handler,
   output logic [7:0]      vec_seen,
   output logic [7:0]      calls,
   output logic [3:0]      depth
);
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------------------------------
   // call and return sequencing
   // ----------------------------------------------------------------
   // ack one cycle after the offer; vector taken at the acknowledging edge
   // since the winner may still change while the offer stands
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         call_ack            <= 1'b0;
         return_from_handler <= 1'b0;
         vec_seen            <= 8'h00;
         calls               <= 8'h00;
         depth               <= 4'h0;
      end else begin
         call_ack            <= int_req && !call_ack;
         return_from_handler <= ret_cmd;
         if (call_ack && int_req) begin
            vec_seen <= int_vector;
            calls    <= calls + 8'h01;
         end
         // only the return address is stacked, status word left alone
         depth <= depth + ((call_ack && int_req) ? 4'h1 : 4'h0)
                  - ((return_from_handler && depth != 4'h0) ? 4'h1 : 4'h0);
      end
   end
endmodule : npiu_core_model

/* nested_priority_interrupt_unit_tb.sv */
// self-checking testbench of the nested priority interrupt unit
`include "npiu_map.svh"
module nested_priority_interrupt_unit_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import npiu_pkg::*;

   typedef struct {int bit_n; logic [7:0] vec; logic clr;} npiu_row_t;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, int_req, irq;
   logic        call_ack, ret_from, ret_cmd, last_err, ce;
   logic [7:0]  paddr, int_vector, vec_seen, calls, ncalls, pulse;
   logic [31:0] pwdata, prdata, q;
   logic [3:0]  in_service, depth;
   logic [1:0]  pin_n;
   int          mismatches, check_count;
   // flag bit, vector, cleared by the call
   npiu_row_t rows[8] = '{'{0, 8'h03, 1'b1}, '{1, 8'h0B, 1'b1}, '{2, 8'h13, 1'b1}, '{3, 8'h1B, 1'b1},
                          '{4, 8'h23, 1'b0}, '{5, 8'h23, 1'b0}, '{6, 8'h2B, 1'b0}, '{7, 8'h2B, 1'b0}};

   npiu_core npiu_core_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext0_pin_n(pin_n[0]), .ext1_pin_n(pin_n[1]), .tmr0_ovf(pulse[1]), .tmr1_ovf(pulse[3]),
      .tmr2_ovf(pulse[6]), .tmr2_ext(pulse[7]), .uart_rx_done(pulse[4]), .uart_tx_done(pulse[5]),
      .int_req(int_req), .int_vector(int_vector), .call_ack(call_ack), .return_from_handler(ret_from),
      .in_service(in_service), .irq(irq));
   npiu_core_model npiu_core_model_inst (.pclk(pclk), .presetn(presetn), .int_req(int_req),
      .int_vector(int_vector), .ret_cmd(ret_cmd), .call_ack(call_ack), .return_from_handler(ret_from),
      .vec_seen(vec_seen), .calls(calls), .depth(depth));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task stop_test();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : stop_test

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // one apb transfer; request held until pready is sampled high
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         mismatches++;
         stop_test();
      end
      q = prdata;
      last_err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb

   task wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask : wr
   task rd(input logic [7:0] a); apb(1'b0, a, 32'h0); endtask : rd

   // pins go low for a few cycles, other sources pulse once
   task fire(input logic [7:0] m);
      @(posedge pclk);
      pin_n <= ~{m[2], m[0]}; pulse <= m & 8'hFA;
      @(posedge pclk);
      pulse <= 8'h00;
      repeat (4) @(posedge pclk);
      pin_n <= 2'b11;
   endtask : fire

   // waits for the next call taken by the core, then checks its vector
   task serve(input logic [7:0] v);
      int n;
      n = 0;
      while (calls !== ncalls + 8'h01 && n < 60) begin
         @(posedge pclk);
         n++;
      end
      if (calls !== ncalls + 8'h01) begin
         mismatches++;
         stop_test();
      end
      ncalls++;
      @(posedge pclk);
      chk("vector", {24'h0, v}, {24'h0, vec_seen});
   endtask : serve

   // return pulse reaches the design two edges later
   task ret();
      @(posedge pclk); ret_cmd <= 1'b1;
      @(posedge pclk); ret_cmd <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask : ret

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
      pin_n = 2'b11; pulse = 8'h00; ret_cmd = 1'b0; ncalls = 8'h00; mismatches = 0; check_count = 0; ce = 1'b1;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("vector after reset", 32'h03, {24'h0, int_vector});
      chk("in service after reset", 32'h0, {28'h0, in_service});
      rd(`NPIU_OFF_ENABLE);
      chk("enable reset", 32'h0, q);
      rd(8'h20);
      chk("unmapped read error", 32'h1, {31'h0, last_err});
      wr(`NPIU_OFF_ENABLE, 32'hBF);
      wr(`NPIU_OFF_TRIGGER, 32'h3);
      // every flag once, flags cleared by software before returning
      foreach (rows[i]) begin
         fire(8'h01 << rows[i].bit_n);
         serve(rows[i].vec);
         rd(`NPIU_OFF_FLAGS);
         chk("flags after call", rows[i].clr ? 32'h0 : 32'h1 << rows[i].bit_n, q);
         wr(`NPIU_OFF_FLAGS, 32'hFF);
         ret();
         chk("in service after return", 32'h0, {28'h0, in_service});
      end
      // level formed from the high and low priority bits
      for (int l = 0; l < 4; l++) begin
         wr(`NPIU_OFF_PRIO_LO, {30'h0, l[0], 1'b0});
         wr(`NPIU_OFF_PRIO_HI, {30'h0, l[1], 1'b0});
         fire(8'h02);
         serve(8'h0B);
         chk("in service level", 32'h1 << l, {28'h0, in_service});
         ret();
      end
      wr(`NPIU_OFF_PRIO_LO, 32'h0);
      wr(`NPIU_OFF_PRIO_HI, 32'h0);
      // same-level ties: one grant at a time, in polling order
      fire(8'h4A);
      serve(8'h0B);
      repeat (8) @(posedge pclk);
      chk("no nested same level", {24'h0, ncalls}, {24'h0, calls});
      ret();
      serve(8'h1B);
      ret();
      serve(8'h2B);
      wr(`NPIU_OFF_FLAGS, 32'hFF);
      ret();
      // higher level pre-empts, lower resumes after its return
      wr(`NPIU_OFF_PRIO_HI, 32'h08);
      fire(8'h02);
      serve(8'h0B);
      fire(8'h08);
      serve(8'h1B);
      chk("nested in service", 32'h5, {28'h0, in_service});
      chk("stack depth", 32'h2, {28'h0, depth});
      ret();
      chk("resumed in service", 32'h1, {28'h0, in_service});
      ret();
      // global enable off: request held, granted once enabled
      wr(`NPIU_OFF_ENABLE, 32'h3F);
      fire(8'h02);
      repeat (8) @(posedge pclk);
      chk("no grant disabled", {24'h0, ncalls}, {24'h0, calls});
      rd(`NPIU_OFF_FLAGS);
      chk("flag pending", 32'h02, q);
      wr(`NPIU_OFF_ENABLE, 32'hBF);
      serve(8'h0B);
      ret();
      // level mode: flag survives the call while the pin stays low
      wr(`NPIU_OFF_TRIGGER, 32'h0);
      @(posedge pclk);
      pin_n <= 2'b10;
      serve(8'h03);
      rd(`NPIU_OFF_FLAGS);
      chk("level flag kept", 32'h01, q);
      pin_n <= 2'b11;
      repeat (6) @(posedge pclk);
      wr(`NPIU_OFF_FLAGS, 32'hFF);
      ret();
      // event status, mask and interrupt line
      rd(`NPIU_OFF_EVT_STAT);
      chk("event status", 32'h3, q);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(`NPIU_OFF_EVT_MASK, 32'h1);
      @(posedge pclk);
      chk("irq unmasked", 32'h1, {31'h0, irq});
      wr(`NPIU_OFF_EVT_STAT, 32'h3);
      @(posedge pclk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      ret();
      rd(`NPIU_OFF_EVT_STAT);
      chk("stray return", 32'h4, q);
      wr(`NPIU_OFF_EVT_MASK, 32'h4);
      @(posedge pclk);
      chk("irq stray", 32'h1, {31'h0, irq});
      // clock enable low: a timer pulse is lost and nothing is offered
      ce <= 1'b0;
      fire(8'h02);
      ce <= 1'b1;
      repeat (8) @(posedge pclk);
      chk("frozen no call", {24'h0, ncalls}, {24'h0, calls});
      rd(`NPIU_OFF_FLAGS);
      chk("frozen no flag", 32'h0, q);
      stop_test();
   end
endmodule : nested_priority_interrupt_unit_tb
